// file: core/radio_afc_tx_timer_commands.v
`timescale 1ns/1ns
`include "radio_afc_tx_timer_regs.vh"
module radio_afc_tx_timer_commands #(
    parameter MS_CYCLES   = `MS_CYCLES,
    parameter MEAS_CYCLES = `MEAS_CYCLES
) (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst_b,
    // serial command port
    input  wire        sel_pin_n,
    input  wire        sck_pin,
    input  wire        sdi_pin,
    // receiver and system inputs
    input  wire        valid_data_flag,
    input  wire [6:0]  freq_error,
    input  wire        tx_data_bit,
    input  wire [1:0]  band_sel,
    input  wire        tx_register_enable,
    input  wire        wakeup_enable,
    // frequency correction results
    output reg  [6:0]  afc_offset_q,
    output reg  [6:0]  synth_offset_q,
    output reg         afc_lock_q,
    output reg         afc_same_q,
    output reg         afc_toggle_q,
    output reg  [4:0]  status_offset_q,
    output reg  [12:0] offset_step_hz_q,
    // transmit modulation and power
    output reg         dev_sign_q,
    output reg  [7:0]  dev_khz_q,
    output reg  [4:0]  power_atten_db_q,
    // synthesizer and oscillator options
    output reg  [1:0]  clkbuf_slew_q,
    output reg         lowpower_osc_q,
    output reg  [1:0]  osc_startup_ms_q,
    output reg         pd_delay_q,
    output reg         dither_off_q,
    output reg         loop_bandwidth_sel_q,
    // transmit data register
    output reg  [7:0]  tx_byte_q,
    output reg         tx_byte_load_q,
    // wake-up timer and duty cycle
    output wire        wake_irq,
    output wire        duty_cycled_receive,
    output wire        rx_window
);
    // ========================================================
    // command registers
    reg  [15:0] fcc_q;
    reg  [15:0] txm_q;
    reg  [15:0] pll_q;
    reg  [15:0] wak_q;
    reg  [15:0] dty_q;
    reg  [15:0] txw_q;
    reg         strobe_prev_q;
    wire [15:0] cmd_word;
    wire        cmd_valid;
    wire [1:0]  mode;
    wire [1:0]  range;

    // scaling constants sized to the outputs they feed
    localparam [12:0] STEP_LOW   = `STEP_HZ_LOW;
    localparam [12:0] STEP_868   = `STEP_HZ_868;
    localparam [12:0] STEP_915   = `STEP_HZ_915;
    localparam [7:0]  DEV_STEP   = `DEV_STEP_KHZ;
    localparam [4:0]  PWR_STEP   = `PWR_STEP_DB;
    localparam [1:0]  XO_START   = `XO_START_MS;
    localparam [1:0]  XO_START_L = `XO_START_LP_MS;

    // opcode match on the fixed upper bits
    function is_cmd;
        input [15:0] w;
        input [15:0] mask;
        input [15:0] val;
        begin
            is_cmd = ((w & mask) == val);
        end
    endfunction

    // clamp a signed 7-bit offset to the selected range
    function [6:0] clamp;
        input [6:0] v;
        input [1:0] r;
        reg   [6:0] hi;
        reg   [6:0] lo;
        begin
            hi = 7'h3F;
            lo = 7'h40;
            case (r)
                2'h1: begin hi = 7'h0F; lo = 7'h70; end
                2'h2: begin hi = 7'h07; lo = 7'h78; end
                2'h3: begin hi = 7'h03; lo = 7'h7C; end
                default: begin hi = 7'h3F; lo = 7'h40; end
            endcase
            if ($signed(v) > $signed(hi)) clamp = hi;
            else if ($signed(v) < $signed(lo)) clamp = lo;
            else clamp = v;
        end
    endfunction

    cmd_shift_in u_shift (
        .core_clk     (core_clk),
        .rst_b        (rst_b),
        .sel_pin_n    (sel_pin_n),
        .sck_pin      (sck_pin),
        .sdi_pin      (sdi_pin),
        .word_q       (cmd_word),
        .word_valid_q (cmd_valid)
    );

    // ========================================================
    // decode: each word updates only the setting it addresses
    always @(posedge core_clk) begin
        if (!rst_b) begin
            fcc_q          <= `FCC_RESET;
            txm_q          <= `TXM_RESET;
            pll_q          <= `PLL_RESET;
            wak_q          <= `WAK_RESET;
            dty_q          <= `DTY_RESET;
            txw_q          <= `TXW_RESET;
            tx_byte_q      <= 8'hAA;
            tx_byte_load_q <= 1'b0;
        end else begin
            tx_byte_load_q <= 1'b0;
            if (cmd_valid) begin
                if (is_cmd(cmd_word, `FCC_MASK, `FCC_MATCH)) fcc_q <= cmd_word;
                if (is_cmd(cmd_word, `TXM_MASK, `TXM_MATCH)) txm_q <= cmd_word;
                // low-power oscillator bit is stored as written by the host
                if (is_cmd(cmd_word, `PLL_MASK, `PLL_MATCH)) pll_q <= cmd_word;
                if (is_cmd(cmd_word, `WAK_MASK, `WAK_MATCH)) wak_q <= cmd_word;
                if (is_cmd(cmd_word, `DTY_MASK, `DTY_MATCH)) dty_q <= cmd_word;
                if (is_cmd(cmd_word, `TXW_MASK, `TXW_MATCH) && tx_register_enable) begin
                    txw_q          <= cmd_word;
                    tx_byte_q      <= cmd_word[7:0];
                    tx_byte_load_q <= 1'b1;
                end
            end
        end
    end

    assign mode  = fcc_q[`FCC_MODE_HI:`FCC_MODE_LO];
    assign range = fcc_q[`FCC_RANGE_HI:`FCC_RANGE_LO];

    // ========================================================
    // measurement cycle: fine mode takes twice as long
    reg  [15:0] meas_cnt_q;
    reg  [6:0]  latest_q;
    reg  [6:0]  prev_q;
    reg         have_prev_q;
    reg         vdi_whole_q;
    reg         vdi_prev_q;
    reg         once_done_q;
    wire [15:0] meas_len;
    wire        meas_end;
    wire        same_now;
    wire        auto_ok;
    wire        strobe_rise;

    assign meas_len = fcc_q[`FCC_FINE] ? MEAS_CYCLES[14:0] << 1
                                       : MEAS_CYCLES[15:0];
    assign meas_end = fcc_q[`FCC_CALC_EN] && (meas_cnt_q == meas_len - 16'h1);
    assign same_now = have_prev_q && (freq_error == latest_q);
    assign auto_ok  = meas_end && vdi_whole_q && valid_data_flag && same_now;
    assign strobe_rise = fcc_q[`FCC_STROBE] && !strobe_prev_q;

    // cycle counter and per-cycle measurement bookkeeping
    always @(posedge core_clk) begin
        if (!rst_b) begin
            meas_cnt_q   <= 16'h0;
            latest_q     <= 7'h00;
            prev_q       <= 7'h00;
            have_prev_q  <= 1'b0;
            vdi_whole_q  <= 1'b1;
            afc_same_q   <= 1'b0;
            afc_toggle_q <= 1'b0;
        end else if (!fcc_q[`FCC_CALC_EN]) begin
            meas_cnt_q  <= 16'h0;    // calculation stopped; results frozen
            vdi_whole_q <= 1'b1;
        end else if (meas_end) begin
            meas_cnt_q   <= 16'h0;
            prev_q       <= latest_q;
            latest_q     <= freq_error;
            have_prev_q  <= 1'b1;
            vdi_whole_q  <= 1'b1;
            afc_same_q   <= same_now;
            afc_toggle_q <= !afc_toggle_q;
        end else begin
            meas_cnt_q  <= meas_cnt_q + 16'h1;
            vdi_whole_q <= vdi_whole_q && valid_data_flag;
        end
    end

    // ========================================================
    // offset register update per mode
    always @(posedge core_clk) begin
        if (!rst_b) begin
            afc_offset_q  <= 7'h00;
            afc_lock_q    <= 1'b0;
            once_done_q   <= 1'b0;
            vdi_prev_q    <= 1'b0;
            strobe_prev_q <= 1'b1;   // power-on strobe bit clear; previous starts high: no false edge
        end else begin
            vdi_prev_q    <= valid_data_flag;
            strobe_prev_q <= fcc_q[`FCC_STROBE];
            case (mode)
                `MODE_OFF: begin
                    afc_lock_q <= 1'b0;
                    if (strobe_rise) afc_offset_q <= clamp(latest_q, range);
                end
                `MODE_ONCE: begin
                    if (auto_ok && !once_done_q) begin
                        afc_offset_q <= clamp(freq_error, range);
                        afc_lock_q   <= 1'b1;
                        once_done_q  <= 1'b1;
                    end
                end
                `MODE_VDI: begin
                    if (vdi_prev_q && !valid_data_flag) begin
                        afc_offset_q <= 7'h00;
                        afc_lock_q   <= 1'b0;
                    end else if (auto_ok) begin
                        afc_offset_q <= clamp(freq_error, range);
                        afc_lock_q   <= 1'b1;
                    end
                end
                `MODE_KEEP: begin
                    // a valid drop does not clear a held value
                    if (auto_ok) begin
                        afc_offset_q <= clamp(freq_error, range);
                        afc_lock_q   <= 1'b1;
                    end
                end
                default: afc_lock_q <= 1'b0;
            endcase
        end
    end

    // ========================================================
    // derived outputs: synth offset, status, tx coding, synth options
    always @(posedge core_clk) begin
        if (!rst_b) begin
            synth_offset_q       <= 7'h00;
            status_offset_q      <= 5'h00;
            offset_step_hz_q     <= 13'h0;
            dev_sign_q           <= 1'b0;
            dev_khz_q            <= 8'h00;
            power_atten_db_q     <= 5'h00;
            clkbuf_slew_q        <= 2'h0;
            lowpower_osc_q       <= 1'b0;
            osc_startup_ms_q     <= 2'h1;
            pd_delay_q           <= 1'b0;
            dither_off_q         <= 1'b0;
            loop_bandwidth_sel_q <= 1'b0;
        end else begin
            synth_offset_q  <= fcc_q[`FCC_OFS_EN] ? afc_offset_q : 7'h00;
            status_offset_q <= {afc_offset_q[6], afc_offset_q[3:0]};
            case (band_sel)
                2'h2:    offset_step_hz_q <= STEP_868;
                2'h3:    offset_step_hz_q <= STEP_915;
                default: offset_step_hz_q <= STEP_LOW;
            endcase
            dev_sign_q <= txm_q[`TXM_POL] ^ tx_data_bit;
            dev_khz_q  <= ({4'h0, txm_q[`TXM_DEV_HI:`TXM_DEV_LO]} + 8'h01)
                          * DEV_STEP;
            power_atten_db_q <= {2'h0, txm_q[`TXM_PWR_HI:`TXM_PWR_LO]}
                                * PWR_STEP;
            // raw code passed on; both 1x codes mean the slowest edges
            clkbuf_slew_q <= pll_q[`PLL_SLEW_HI:`PLL_SLEW_LO];
            lowpower_osc_q   <= pll_q[`PLL_LPX];
            osc_startup_ms_q <= pll_q[`PLL_LPX] ? XO_START_L : XO_START;
            pd_delay_q       <= pll_q[`PLL_DDY];
            dither_off_q     <= pll_q[`PLL_DDIT];
            loop_bandwidth_sel_q <= pll_q[`PLL_BW];
        end
    end

    // ========================================================
    // wake-up timer and duty-cycled receive
    assign duty_cycled_receive = dty_q[`DTY_EN];

    wake_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_wake (
        .core_clk      (core_clk),
        .rst_b         (rst_b),
        .exponent      (wak_q[`WAK_EXP_HI:`WAK_EXP_LO]),
        .mantissa      (wak_q[`WAK_MAN_HI:`WAK_MAN_LO]),
        .duty_d        (dty_q[`DTY_D_HI:`DTY_D_LO]),
        .duty_en       (dty_q[`DTY_EN]),
        .wakeup_enable (wakeup_enable),
        .wake_irq_q    (wake_irq),
        .rx_window_q   (rx_window)
    );
endmodule // radio_afc_tx_timer_commands

// file: core/radio_afc_tx_timer_regs.vh
`ifndef RADIO_AFC_TX_TIMER_REGS_VH
`define RADIO_AFC_TX_TIMER_REGS_VH

// ============================================================
// command opcode masks and match values
`define FCC_MASK      16'hFF00
`define FCC_MATCH     16'hC400
`define TXM_MASK      16'hFE00
`define TXM_MATCH     16'h9800
`define PLL_MASK      16'hFF80
`define PLL_MATCH     16'hCC00
`define TXW_MASK      16'hFF00
`define TXW_MATCH     16'hB800
`define WAK_MASK      16'hE000
`define WAK_MATCH     16'hE000
`define DTY_MASK      16'hFE00
`define DTY_MATCH     16'hC800

// ============================================================
// power-on values
`define FCC_RESET     16'hC4F7
`define TXM_RESET     16'h9800
`define PLL_RESET     16'hCC67
`define TXW_RESET     16'hB8AA
`define WAK_RESET     16'hE196
`define DTY_RESET     16'hC80E

// ============================================================
// freq_correction_control fields
`define FCC_MODE_HI   7
`define FCC_MODE_LO   6
`define FCC_RANGE_HI  5
`define FCC_RANGE_LO  4
`define FCC_STROBE    3
`define FCC_FINE      2
`define FCC_OFS_EN    1
`define FCC_CALC_EN   0

// automatic mode codes
`define MODE_OFF      2'h0
`define MODE_ONCE     2'h1
`define MODE_VDI      2'h2
`define MODE_KEEP     2'h3

// tx_modulation_power fields
`define TXM_POL       8
`define TXM_DEV_HI    7
`define TXM_DEV_LO    4
`define TXM_PWR_HI    2
`define TXM_PWR_LO    0

// synth_loop_settings fields
`define PLL_SLEW_HI   6
`define PLL_SLEW_LO   5
`define PLL_LPX       4
`define PLL_DDY       3
`define PLL_DDIT      2
`define PLL_BW        0

// wakeup_period and duty_cycle_control fields
`define WAK_EXP_HI    12
`define WAK_EXP_LO    8
`define WAK_MAN_HI    7
`define WAK_MAN_LO    0
`define DTY_D_HI      7
`define DTY_D_LO      1
`define DTY_EN        0

// ============================================================
// timing and scaling
`define CLK_MHZ        250
`define MEAS_NS        2000
`define MEAS_CYCLES    ((`MEAS_NS * `CLK_MHZ) / 1000)
`define MS_CYCLES      (1000 * `CLK_MHZ)
`define DEV_STEP_KHZ   15
`define PWR_STEP_DB    3
`define STEP_HZ_LOW    2500
`define STEP_HZ_868    5000
`define STEP_HZ_915    7500
`define XO_START_MS    1
`define XO_START_LP_MS 2

`endif

// file: core/cmd_shift_in.v
`timescale 1ns/1ns
// ============================================================
// serial command receiver: pins pass three flops, 16 bits -> word
module cmd_shift_in (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst_b,
    // serial pins
    input  wire        sel_pin_n,
    input  wire        sck_pin,
    input  wire        sdi_pin,
    // word output
    output reg  [15:0] word_q,
    output reg         word_valid_q
);
    reg [2:0]  sel_s_q;
    reg [2:0]  sck_s_q;
    reg [2:0]  sdi_s_q;
    reg        sel_st_q;
    reg        sck_st_q;
    reg        sdi_st_q;
    reg [15:0] shift_q;
    reg [4:0]  count_q;
    wire       sck_rise;

    // three-flop synchronisers; a level counts once stages 2 and 3 agree
    always @(posedge core_clk) begin
        if (!rst_b) begin
            sel_s_q  <= 3'h7;
            sck_s_q  <= 3'h0;
            sdi_s_q  <= 3'h0;
            sel_st_q <= 1'b1;
            sck_st_q <= 1'b0;
            sdi_st_q <= 1'b0;
        end else begin
            sel_s_q <= {sel_s_q[1:0], sel_pin_n};
            sck_s_q <= {sck_s_q[1:0], sck_pin};
            sdi_s_q <= {sdi_s_q[1:0], sdi_pin};
            if (sel_s_q[1] == sel_s_q[2]) sel_st_q <= sel_s_q[2];
            if (sck_s_q[1] == sck_s_q[2]) sck_st_q <= sck_s_q[2];
            if (sdi_s_q[1] == sdi_s_q[2]) sdi_st_q <= sdi_s_q[2];
        end
    end

    assign sck_rise = !sck_st_q && sck_s_q[1] && sck_s_q[2];

    // msb first; only the first 16 bits of a frame form a command
    always @(posedge core_clk) begin
        if (!rst_b) begin
            shift_q      <= 16'h0000;
            count_q      <= 5'h00;
            word_q       <= 16'h0000;
            word_valid_q <= 1'b0;
        end else begin
            word_valid_q <= 1'b0;
            if (sel_st_q) begin
                count_q <= 5'h00;            // short frame is dropped
            end else if (sck_rise && count_q != 5'h10) begin
                shift_q <= {shift_q[14:0], sdi_st_q};
                count_q <= count_q + 5'h01;
                if (count_q == 5'h0F) begin
                    word_q       <= {shift_q[14:0], sdi_st_q};
                    word_valid_q <= 1'b1;
                end
            end
        end
    end
endmodule // cmd_shift_in

// file: core/wake_timer.v
`timescale 1ns/1ns
`include "radio_afc_tx_timer_regs.vh"
// ============================================================
// wake-up period timer and duty-cycled receive window
module wake_timer #(
    parameter MS_CYCLES = `MS_CYCLES
) (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst_b,
    // settings
    input  wire [4:0]  exponent,
    input  wire [7:0]  mantissa,
    input  wire [6:0]  duty_d,
    input  wire        duty_en,
    input  wire        wakeup_enable,
    // results
    output reg         wake_irq_q,
    output reg         rx_window_q
);
    reg  [17:0] div_q;
    reg  [36:0] ms_q;
    reg         armed_q;
    reg         ew_prev_q;
    wire        ms_tick;
    wire [36:0] period_ms;
    wire [36:0] on_ms;

    // period is mantissa * 2^exponent ms; on time (2D+1) * 2^exponent ms
    assign period_ms = {29'h0, mantissa} << exponent;
    assign on_ms     = {29'h0, duty_d, 1'b1} << exponent;
    assign ms_tick   = (div_q == MS_CYCLES[17:0] - 18'h1);

    // millisecond divider; restarts on arming so the period is exact, not one ms short
    always @(posedge core_clk) begin
        if (!rst_b) div_q <= 18'h0;
        else if (ms_tick || (wakeup_enable && !ew_prev_q)) div_q <= 18'h0;
        else div_q <= div_q + 18'h1;
    end

    // one shot per arming outside duty mode; host re-arms by clearing then setting enable
    always @(posedge core_clk) begin
        if (!rst_b) begin
            ms_q        <= 37'h0;
            armed_q     <= 1'b0;
            ew_prev_q   <= 1'b0;
            wake_irq_q  <= 1'b0;
            rx_window_q <= 1'b0;
        end else begin
            ew_prev_q  <= wakeup_enable;
            wake_irq_q <= 1'b0;
            if (wakeup_enable && !ew_prev_q) begin
                armed_q <= 1'b1;
                ms_q    <= 37'h0;
            end else if (!wakeup_enable) begin
                armed_q <= duty_en;
            end else if (armed_q && ms_tick) begin
                if (ms_q + 37'h1 >= period_ms) begin
                    ms_q       <= 37'h0;
                    armed_q    <= duty_en;  // duty mode keeps cycling
                    wake_irq_q <= !duty_en;
                end else begin
                    ms_q <= ms_q + 37'h1;
                end
            end
            // arming edge excluded: ms_q is only cleared there
            rx_window_q <= duty_en && wakeup_enable && ew_prev_q && (ms_q < on_ms);
        end
    end
endmodule // wake_timer

// file: sim/radio_cmd_sva.sv
`timescale 1ns/1ns
// ============================================================
// port checks of the command block
module radio_cmd_sva (
    // clock and reset
    input wire        core_clk,
    input wire        rst_b,
    // watched ports
    input wire [1:0]  band_sel,
    input wire        tx_register_enable,
    input wire [6:0]  afc_offset_q,
    input wire        afc_toggle_q,
    input wire [4:0]  status_offset_q,
    input wire [12:0] offset_step_hz_q,
    input wire [4:0]  power_atten_db_q,
    input wire        lowpower_osc_q,
    input wire [1:0]  osc_startup_ms_q,
    input wire [7:0]  tx_byte_q,
    input wire        tx_byte_load_q,
    input wire        wake_irq,
    input wire        duty_cycled_receive
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // offset one cycle back, since the status copy lags by one
    logic [6:0] ofs_prev;
    always @(posedge core_clk) ofs_prev <= afc_offset_q;
    // a load is a lone one-cycle pulse
    sequence load_pulse; tx_byte_load_q ##1 !tx_byte_load_q; endsequence
    AST_STEP: assert property ($past(rst_b) |-> offset_step_hz_q ==
        ($past(band_sel) == 2'h2 ? 13'h1388 : $past(band_sel) == 2'h3 ? 13'h1D4C : 13'h09C4))
        else $error("step size wrong");
    AST_STATUS: assert property ($past(rst_b) |->
        status_offset_q == {ofs_prev[6], ofs_prev[3:0]}) else $error("status offset wrong");
    AST_POWER: assert property (power_atten_db_q % 5'h03 == 5'h00 &&
        power_atten_db_q <= 5'h15) else $error("power step wrong");
    AST_OSC: assert property ($stable(lowpower_osc_q) |->
        osc_startup_ms_q == {lowpower_osc_q, !lowpower_osc_q}) else $error("start-up wrong");
    AST_LOAD: assert property ($changed(tx_byte_q) |->
        tx_byte_load_q || $past(tx_byte_load_q)) else $error("byte changed without load");
    AST_PULSE: assert property (tx_byte_load_q |-> tx_register_enable ##0 load_pulse)
        else $error("bad load pulse");
    AST_IRQ: assert property (wake_irq |=> !wake_irq) else $error("wake pulse too long");
    AST_DUTY: assert property (duty_cycled_receive && $past(duty_cycled_receive)
        |-> !wake_irq) else $error("wake pulse in duty mode");
    AST_TOGGLE: assert property ($changed(afc_toggle_q) |=>
        $stable(afc_toggle_q)[*7]) else $error("toggle too fast");
endmodule // radio_cmd_sva

// file: sim/host_serial_model.sv
`timescale 1ns/1ns
// ============================================================
// host side of the serial command port
module host_serial_model (
    // clock
    input  wire  core_clk,
    // serial pins
    output logic sel_pin_n,
    output logic sck_pin,
    output logic sdi_pin
);
    // idle: deselected, serial clock parked low
    initial begin
        sel_pin_n = 1'b1;
        sck_pin = 1'b0;
        sdi_pin = 1'b0;
    end
    // whole word, msb first; 20 core cycles per half of the 160 ns clock
    task automatic send(input logic [15:0] w);
        @(negedge core_clk);
        sel_pin_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi_pin = w[i];
            repeat (20) @(negedge core_clk);
            sck_pin = 1'b1;
            repeat (20) @(negedge core_clk);
            sck_pin = 1'b0;
        end
        repeat (20) @(negedge core_clk);
        sel_pin_n = 1'b1; // frame end resets the bit count
        sdi_pin = ~sdi_pin; // data line inverted; ignored while deselected, so no stale bit
        repeat (12) @(negedge core_clk);
    endtask
endmodule // host_serial_model

// file: sim/tb.sv
`timescale 1ns/1ns
// ============================================================
// bench: serial command writes, then port checks
module tb;
    // inputs, pins and outputs
    logic        core_clk, rst_b, valid_data_flag, tx_data_bit;
    logic        tx_register_enable, wakeup_enable;
    logic [6:0]  freq_error;
    logic [1:0]  band_sel;
    wire         sel_pin_n, sck_pin, sdi_pin;
    wire  [6:0]  afc_offset_q, synth_offset_q;
    wire  [4:0]  status_offset_q, power_atten_db_q;
    wire  [12:0] offset_step_hz_q;
    wire  [7:0]  dev_khz_q, tx_byte_q;
    wire  [1:0]  clkbuf_slew_q, osc_startup_ms_q;
    wire         afc_lock_q, afc_same_q, afc_toggle_q, dev_sign_q, lowpower_osc_q;
    wire         pd_delay_q, dither_off_q, loop_bandwidth_sel_q, tx_byte_load_q;
    wire         wake_irq, duty_cycled_receive, rx_window;
    int          mismatches, comparisons, n, k, w;
    // short counts keep runs small
    radio_afc_tx_timer_commands #(.MS_CYCLES(10), .MEAS_CYCLES(8))
        radio_afc_tx_timer_commands_i (
        .core_clk(core_clk), .rst_b(rst_b), .sel_pin_n(sel_pin_n), .sck_pin(sck_pin),
        .sdi_pin(sdi_pin), .valid_data_flag(valid_data_flag), .freq_error(freq_error),
        .tx_data_bit(tx_data_bit), .band_sel(band_sel),
        .tx_register_enable(tx_register_enable), .wakeup_enable(wakeup_enable),
        .afc_offset_q(afc_offset_q), .synth_offset_q(synth_offset_q),
        .afc_lock_q(afc_lock_q), .afc_same_q(afc_same_q), .afc_toggle_q(afc_toggle_q),
        .status_offset_q(status_offset_q), .offset_step_hz_q(offset_step_hz_q),
        .dev_sign_q(dev_sign_q), .dev_khz_q(dev_khz_q), .power_atten_db_q(power_atten_db_q),
        .clkbuf_slew_q(clkbuf_slew_q), .lowpower_osc_q(lowpower_osc_q),
        .osc_startup_ms_q(osc_startup_ms_q), .pd_delay_q(pd_delay_q),
        .dither_off_q(dither_off_q), .loop_bandwidth_sel_q(loop_bandwidth_sel_q),
        .tx_byte_q(tx_byte_q), .tx_byte_load_q(tx_byte_load_q), .wake_irq(wake_irq),
        .duty_cycled_receive(duty_cycled_receive), .rx_window(rx_window));
    host_serial_model host_serial_model_i (.core_clk(core_clk), .sel_pin_n(sel_pin_n),
        .sck_pin(sck_pin), .sdi_pin(sdi_pin));
    always #2 core_clk = ~core_clk;
    // compare and count
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // write a correction word, wait bounded for the expected offset
    task automatic afc(input logic [15:0] c, input logic [6:0] e, input logic [6:0] x);
        freq_error = e;
        host_serial_model_i.send(c);
        for (n = 0; n < 300 && afc_offset_q !== x; n++) @(negedge core_clk);
        chk(afc_offset_q, x);
        if (n == 300) test_done();
    endtask
    initial begin
        core_clk = 0;
        {rst_b, valid_data_flag, tx_data_bit, tx_register_enable, wakeup_enable} = 0;
        freq_error = 7'h00;
        band_sel = 2'h0;
        repeat (12) @(negedge core_clk);
        rst_b = 1;
        repeat (3) @(negedge core_clk);
        chk({dev_khz_q, tx_byte_q}, 16'h0FAA);
        chk({clkbuf_slew_q, loop_bandwidth_sel_q, dither_off_q, pd_delay_q}, 5'h1E);
        $display("reset test done");
        host_serial_model_i.send(16'h99F5);
        chk({dev_sign_q, dev_khz_q, power_atten_db_q}, {1'b1, 8'hF0, 5'h0F});
        tx_data_bit = 1;
        repeat (3) @(negedge core_clk);
        chk(dev_sign_q, 1'b0);
        host_serial_model_i.send(16'hCC77);
        chk({clkbuf_slew_q, lowpower_osc_q, osc_startup_ms_q, pd_delay_q, dither_off_q,
            loop_bandwidth_sel_q}, 8'hF3);
        host_serial_model_i.send(16'hCC0C);
        host_serial_model_i.send(16'hA123);
        chk({clkbuf_slew_q, lowpower_osc_q, osc_startup_ms_q, pd_delay_q, dither_off_q,
            loop_bandwidth_sel_q}, 8'h0E);
        chk(dev_khz_q, 8'hF0);
        host_serial_model_i.send(16'hB855);
        chk(tx_byte_q, 8'hAA);
        tx_register_enable = 1;
        host_serial_model_i.send(16'hB855);
        chk(tx_byte_q, 8'h55);
        for (n = 0; n < 4; n++) begin
            band_sel = n[1:0];
            repeat (2) @(negedge core_clk);
            chk(offset_step_hz_q, n < 2 ? 13'h09C4 : n == 2 ? 13'h1388 : 13'h1D4C);
        end
        $display("settings test done");
        afc(16'hC403, 7'h25, 7'h00);
        afc(16'hC40B, 7'h25, 7'h25);
        chk(synth_offset_q, 7'h25);
        afc(16'hC433, 7'h25, 7'h25);
        afc(16'hC43B, 7'h25, 7'h03);
        valid_data_flag = 1;
        afc(16'hC483, 7'h12, 7'h12);
        chk(afc_lock_q, 1'b1);
        chk(afc_same_q, 1'b1);
        valid_data_flag = 0;
        repeat (3) @(negedge core_clk);
        chk(afc_offset_q, 7'h00);
        valid_data_flag = 1;
        afc(16'hC4C3, 7'h7B, 7'h7B);
        @(negedge core_clk);
        chk(status_offset_q, 5'h1B);
        valid_data_flag = 0;
        repeat (20) @(negedge core_clk);
        chk(afc_offset_q, 7'h7B);
        valid_data_flag = 1;
        afc(16'hC443, 7'h08, 7'h08);
        freq_error = 7'h09;
        repeat (100) @(negedge core_clk);
        chk(afc_offset_q, 7'h08);
        $display("correction test done");
        host_serial_model_i.send(16'hE203);
        wakeup_enable = 1;
        for (n = 0; n < 400 && wake_irq !== 1'b1; n++) @(negedge core_clk);
        chk(n >= 118 && n <= 122, 1'b1);
        if (n == 400) test_done();
        wakeup_enable = 0;
        host_serial_model_i.send(16'hE208);
        host_serial_model_i.send(16'hC803);
        wakeup_enable = 1;
        // 32 ms period, 12 ms window; runs past the period end into the next window
        repeat (325) begin
            @(negedge core_clk);
            k += rx_window;
            w += wake_irq;
        end
        chk({duty_cycled_receive, k[14:0]}, 16'h807C);
        chk(w[15:0], 16'h0000);
        $display("wake test done");
        test_done();
    end
endmodule // tb
bind radio_afc_tx_timer_commands radio_cmd_sva radio_cmd_sva_i (.*);
